// ---- hdl/psc_ctrl.sv ----
// Parameter store controller: save, discard, marker and restart objects.
`timescale 1ns/1ps

// Behaviour
// - Save signature on subentry stores its category
// - Successful store overwrites subentry with one
// - Subentry to category mapping, 01 excludes tuning
// - Load signature on discard erases category
// - Factory reset keeps tuning; 06 clears it
// - Discard leaves active values until restart
// - Boot signature on restart subentry restarts
// - Marker accepts date, time; saved by 01
// - Savable writes clear marker, except 01/marker
// - Stored values reload at every reset
// - Only whole categories are ever stored
module psc_ctrl
(
  // Clock and reset.
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // Register port.
  input  wire logic [psc_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [psc_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output      logic [psc_pkg::DATA_W-1:0]    reg_rdata,
  // Writes to savable objects elsewhere in the dictionary.
  input  wire logic                          od_obj_write,
  // Nonvolatile store handshake.
  output      logic                          nv_req,
  output      logic [1:0]                    nv_op,
  output      logic [psc_pkg::NCAT-1:0]      nv_cat,
  input  wire logic                          nv_ack,
  input  wire logic                          nv_ok,
  input  wire logic [psc_pkg::DATA_W-1:0]    nv_load_date,
  input  wire logic [psc_pkg::DATA_W-1:0]    nv_load_time,
  output      logic [psc_pkg::DATA_W-1:0]    nv_mark_date,
  output      logic [psc_pkg::DATA_W-1:0]    nv_mark_time,
  // System.
  output      logic                          reboot_req,
  output      logic                          irq
);

  psc_pkg::psc_state_t            state_reg;
  psc_pkg::psc_state_t            state_next;
  logic [psc_pkg::DATA_W-1:0]     save_reg [psc_pkg::NSLOT];
  logic [psc_pkg::DATA_W-1:0]     save_next [psc_pkg::NSLOT];
  logic [psc_pkg::DATA_W-1:0]     disc_reg [psc_pkg::NSLOT];
  logic [psc_pkg::DATA_W-1:0]     disc_next [psc_pkg::NSLOT];
  logic [psc_pkg::NSLOT-1:0]      spend_reg;
  logic [psc_pkg::NSLOT-1:0]      spend_next;
  logic [psc_pkg::NSLOT-1:0]      dpend_reg;
  logic [psc_pkg::NSLOT-1:0]      dpend_next;
  logic [2:0]                     slot_reg;
  logic [2:0]                     slot_next;
  logic [1:0]                     op_reg;
  logic [1:0]                     op_next;
  logic [psc_pkg::NCAT-1:0]       cat_reg;
  logic [psc_pkg::NCAT-1:0]       cat_next;
  logic [psc_pkg::DATA_W-1:0]     date_reg;
  logic [psc_pkg::DATA_W-1:0]     date_next;
  logic [psc_pkg::DATA_W-1:0]     time_reg;
  logic [psc_pkg::DATA_W-1:0]     time_next;
  logic [psc_pkg::NEVT-1:0]       stat_reg;
  logic [psc_pkg::NEVT-1:0]       stat_next;
  logic [psc_pkg::NEVT-1:0]       mask_reg;
  logic [psc_pkg::NEVT-1:0]       mask_next;
  logic [psc_pkg::DATA_W-1:0]     rdata_reg;
  logic [psc_pkg::DATA_W-1:0]     rdata_next;
  logic                           reboot_reg;
  logic                           reboot_next;

  // Maps a save or discard subentry to its slot.
  // Subentry selects category
  function automatic logic [2:0] slot_of(input logic [7:0] sub);
    logic [2:0] s;
    s = psc_pkg::SLOT_NONE;
    unique case (sub)
      psc_pkg::SUB_ALL:    s = 3'h0;
      psc_pkg::SUB_COMM:   s = 3'h1;
      psc_pkg::SUB_APP:    s = 3'h2;
      psc_pkg::SUB_USER:   s = 3'h3;
      psc_pkg::SUB_MOVE:   s = 3'h4;
      psc_pkg::SUB_TUNE:   s = 3'h5;
      psc_pkg::SUB_MODBUS: s = 3'h6;
      default:             s = psc_pkg::SLOT_NONE;
    endcase
    return s;
  endfunction

  // Category mask of a slot; the all slot never includes tuning.
  function automatic logic [psc_pkg::NCAT-1:0] cat_of(input logic [2:0] s);
    logic [psc_pkg::NCAT-1:0] m;
    m = '0;
    unique case (s)
      3'h0:    m = psc_pkg::CAT_NOTUNE;
      3'h1:    m[psc_pkg::CAT_COMM] = 1'b1;
      3'h2:    m[psc_pkg::CAT_APP] = 1'b1;
      3'h3:    m[psc_pkg::CAT_USER] = 1'b1;
      3'h4:    m[psc_pkg::CAT_MOVE] = 1'b1;
      3'h5:    m[psc_pkg::CAT_TUNE] = 1'b1;
      3'h6:    m[psc_pkg::CAT_MBUS] = 1'b1;
      default: m = '0;
    endcase
    return m;
  endfunction

  always_comb
  begin
    logic [15:0]              idx;
    logic [7:0]               sub;
    logic [2:0]               wslot;
    logic                     found;
    logic [psc_pkg::NEVT-1:0] sets;
    {idx, sub} = reg_addr;
    wslot = slot_of(sub);
    found = 1'b0;
    sets = '0;
    state_next = state_reg;
    save_next = save_reg;
    disc_next = disc_reg;
    spend_next = spend_reg;
    dpend_next = dpend_reg;
    slot_next = slot_reg;
    op_next = op_reg;
    cat_next = cat_reg;
    date_next = date_reg;
    time_next = time_reg;
    stat_next = stat_reg;
    mask_next = mask_reg;
    rdata_next = '0;
    reboot_next = 1'b0;

    unique case (state_reg)
      psc_pkg::ST_BOOT:
      begin
        if (nv_ack)
        begin
          date_next = nv_load_date;
          time_next = nv_load_time;
          sets[psc_pkg::EV_LOADED] = 1'b1;
          sets[psc_pkg::EV_NVERR] = ~nv_ok;
          state_next = psc_pkg::ST_IDLE;
        end
      end
      psc_pkg::ST_IDLE:
      begin
        // Saves are served before discards, lowest slot first.
        for (int i = 0; i < psc_pkg::NSLOT; i++)
        begin
          if (spend_reg[i] && !found)
          begin
            found = 1'b1;
            slot_next = 3'(i);
            op_next = psc_pkg::NV_OP_SAVE;
            spend_next[i] = 1'b0;
          end
        end
        for (int i = 0; i < psc_pkg::NSLOT; i++)
        begin
          if (dpend_reg[i] && !found)
          begin
            found = 1'b1;
            slot_next = 3'(i);
            op_next = psc_pkg::NV_OP_ERASE;
            dpend_next[i] = 1'b0;
          end
        end
        if (found)
        begin
          cat_next = cat_of(slot_next);
          state_next = psc_pkg::ST_RUN;
        end
      end
      psc_pkg::ST_RUN:
      begin
        if (nv_ack)
        begin
          state_next = psc_pkg::ST_IDLE;
          if (!nv_ok)
          begin
            sets[psc_pkg::EV_NVERR] = 1'b1;
          end
          else if (op_reg == psc_pkg::NV_OP_SAVE)
          begin
            save_next[slot_reg] = psc_pkg::SAVE_DONE;
            sets[psc_pkg::EV_SAVED] = 1'b1;
          end
          else
          begin
            sets[psc_pkg::EV_ERASED] = 1'b1;
          end
        end
      end
    endcase

    if (od_obj_write)
    begin
      date_next = psc_pkg::MARK_CLEAR;
      time_next = psc_pkg::MARK_CLEAR;
      sets[psc_pkg::EV_MARKCLR] = 1'b1;
    end

    if (reg_wr)
    begin
      if (idx == psc_pkg::IDX_STORE && wslot != psc_pkg::SLOT_NONE)
      begin
        save_next[wslot] = reg_wdata;
        if (reg_wdata == psc_pkg::SIG_SAVE)
        begin
          spend_next[wslot] = 1'b1;
        end
        if (sub != psc_pkg::SUB_ALL)
        begin
          date_next = psc_pkg::MARK_CLEAR;
          time_next = psc_pkg::MARK_CLEAR;
          sets[psc_pkg::EV_MARKCLR] = 1'b1;
        end
      end
      if (idx == psc_pkg::IDX_DISCARD && wslot != psc_pkg::SLOT_NONE)
      begin
        disc_next[wslot] = reg_wdata;
        if (reg_wdata == psc_pkg::SIG_LOAD)
        begin
          dpend_next[wslot] = 1'b1;
        end
      end
      if (idx == psc_pkg::IDX_MARKER && sub == psc_pkg::SUB_DATE)
      begin
        date_next = reg_wdata;
      end
      if (idx == psc_pkg::IDX_MARKER && sub == psc_pkg::SUB_TIME)
      begin
        time_next = reg_wdata;
      end
      if (idx == psc_pkg::IDX_REBOOT && sub == psc_pkg::SUB_RESTART)
      begin
        reboot_next = (reg_wdata == psc_pkg::SIG_BOOT);
        date_next = psc_pkg::MARK_CLEAR;
        time_next = psc_pkg::MARK_CLEAR;
        sets[psc_pkg::EV_MARKCLR] = 1'b1;
      end
      if (idx == psc_pkg::IDX_IRQ && sub == psc_pkg::SUB_MASK)
      begin
        mask_next = reg_wdata[psc_pkg::NEVT-1:0];
      end
    end

    if (reg_rd)
    begin
      if (idx == psc_pkg::IDX_STORE && wslot != psc_pkg::SLOT_NONE)
      begin
        rdata_next = save_reg[wslot];
      end
      if (idx == psc_pkg::IDX_DISCARD && wslot != psc_pkg::SLOT_NONE)
      begin
        rdata_next = disc_reg[wslot];
      end
      if (idx == psc_pkg::IDX_MARKER && sub == psc_pkg::SUB_DATE)
      begin
        rdata_next = date_reg;
      end
      if (idx == psc_pkg::IDX_MARKER && sub == psc_pkg::SUB_TIME)
      begin
        rdata_next = time_reg;
      end
      if (idx == psc_pkg::IDX_IRQ && sub == psc_pkg::SUB_STATUS)
      begin
        rdata_next = {{(psc_pkg::DATA_W-psc_pkg::NEVT){1'b0}}, stat_reg};
        stat_next = psc_pkg::EV_RESET;
      end
      if (idx == psc_pkg::IDX_IRQ && sub == psc_pkg::SUB_MASK)
      begin
        rdata_next = {{(psc_pkg::DATA_W-psc_pkg::NEVT){1'b0}}, mask_reg};
      end
    end

    // New events win over a clearing read in the same cycle.
    stat_next = stat_next | sets;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_reg <= psc_pkg::ST_BOOT;
      for (int i = 0; i < psc_pkg::NSLOT; i++)
      begin
        save_reg[i] <= '0;
        disc_reg[i] <= '0;
      end
      spend_reg <= '0;
      dpend_reg <= '0;
      slot_reg <= '0;
      op_reg <= psc_pkg::NV_OP_LOAD;
      cat_reg <= psc_pkg::CAT_EVERY;
      date_reg <= psc_pkg::MARK_CLEAR;
      time_reg <= psc_pkg::MARK_CLEAR;
      stat_reg <= psc_pkg::EV_RESET;
      mask_reg <= psc_pkg::EV_RESET;
      rdata_reg <= '0;
      reboot_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      save_reg <= save_next;
      disc_reg <= disc_next;
      spend_reg <= spend_next;
      dpend_reg <= dpend_next;
      slot_reg <= slot_next;
      op_reg <= op_next;
      cat_reg <= cat_next;
      date_reg <= date_next;
      time_reg <= time_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      reboot_reg <= reboot_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign nv_req = (state_reg != psc_pkg::ST_IDLE);
  assign nv_op = op_reg;
  assign nv_cat = cat_reg;
  assign nv_mark_date = date_reg;
  assign nv_mark_time = time_reg;
  assign reboot_req = reboot_reg;
  assign irq = |(stat_reg & mask_reg);

endmodule // psc_ctrl

// ---- shared/psc_pkg.sv ----
// Constants shared by the parameter store controller.
package psc_pkg;

  // Register address is {object index, subentry}.
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;

  // Object indices.
  localparam logic [15:0] IDX_STORE   = 16'h1010;
  localparam logic [15:0] IDX_DISCARD = 16'h1011;
  localparam logic [15:0] IDX_MARKER  = 16'h1020;
  localparam logic [15:0] IDX_REBOOT  = 16'h2800;
  localparam logic [15:0] IDX_IRQ     = 16'h3f00;

  // Subentries.
  localparam logic [7:0] SUB_ALL     = 8'h01;
  localparam logic [7:0] SUB_COMM    = 8'h02;
  localparam logic [7:0] SUB_APP     = 8'h03;
  localparam logic [7:0] SUB_USER    = 8'h04;
  localparam logic [7:0] SUB_MOVE    = 8'h05;
  localparam logic [7:0] SUB_TUNE    = 8'h06;
  localparam logic [7:0] SUB_MODBUS  = 8'h0b;
  localparam logic [7:0] SUB_DATE    = 8'h01;
  localparam logic [7:0] SUB_TIME    = 8'h02;
  localparam logic [7:0] SUB_RESTART = 8'h01;
  localparam logic [7:0] SUB_STATUS  = 8'h01;
  localparam logic [7:0] SUB_MASK    = 8'h02;

  // Signatures and completion value.
  localparam logic [31:0] SIG_SAVE    = 32'h65766173;
  localparam logic [31:0] SIG_LOAD    = 32'h64616f6c;
  localparam logic [31:0] SIG_BOOT    = 32'h746f6f62;
  localparam logic [31:0] SAVE_DONE   = 32'h00000001;
  localparam logic [31:0] MARK_CLEAR  = 32'h00000000;

  // Subentry slots, one per selectable subentry.
  localparam int          NSLOT     = 7;
  localparam logic [2:0]  SLOT_NONE = 3'h7;

  // Category mask bits sent to the nonvolatile store.
  localparam int          NCAT      = 6;
  localparam int          CAT_COMM  = 0;
  localparam int          CAT_APP   = 1;
  localparam int          CAT_USER  = 2;
  localparam int          CAT_MOVE  = 3;
  localparam int          CAT_TUNE  = 4;
  localparam int          CAT_MBUS  = 5;
  localparam logic [5:0]  CAT_EVERY = 6'h3f;
  localparam logic [5:0]  CAT_NOTUNE = 6'h2f;

  // Store operations.
  localparam logic [1:0] NV_OP_LOAD  = 2'h0;
  localparam logic [1:0] NV_OP_SAVE  = 2'h1;
  localparam logic [1:0] NV_OP_ERASE = 2'h2;

  // Interrupt status bits.
  localparam int         NEVT       = 5;
  localparam int         EV_SAVED   = 0;
  localparam int         EV_ERASED  = 1;
  localparam int         EV_MARKCLR = 2;
  localparam int         EV_NVERR   = 3;
  localparam int         EV_LOADED  = 4;
  localparam logic [4:0] EV_RESET   = 5'h00;

  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_RUN} psc_state_t;

endpackage

// ---- bench/psc_ctrl_sva.sv ----
// Port assertions for the parameter store controller.
`timescale 1ns/1ps
module psc_ctrl_sva
(
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        rst,
  // Register port.
  input wire logic [23:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        od_obj_write,
  // Store side and system.
  input wire logic        nv_req,
  input wire logic [1:0]  nv_op,
  input wire logic [5:0]  nv_cat,
  input wire logic        nv_ack,
  input wire logic [31:0] nv_mark_date,
  input wire logic [31:0] nv_mark_time,
  input wire logic        reboot_req
);
  logic boot_wr;
  logic mk_wr;
  assign boot_wr = reg_wr && reg_wdata == psc_pkg::SIG_BOOT
    && reg_addr == {psc_pkg::IDX_REBOOT, psc_pkg::SUB_RESTART};
  assign mk_wr = reg_wr && reg_addr[23:8] == psc_pkg::IDX_MARKER;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_boot_load: assert property (
    $fell(rst) |-> nv_req && nv_op == psc_pkg::NV_OP_LOAD
      && nv_cat == psc_pkg::CAT_EVERY) else $error("no boot load");
  a_save_cats: assert property (
    $rose(nv_req) && nv_op == psc_pkg::NV_OP_SAVE |-> nv_cat inside
      {6'h2f, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20})
    else $error("bad save mask");
  a_erase_cats: assert property (
    $rose(nv_req) && nv_op == psc_pkg::NV_OP_ERASE |-> nv_cat inside
      {6'h2f, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20})
    else $error("bad erase mask");
  a_req_hold: assert property (
    nv_req && !nv_ack |=> nv_req && $stable(nv_op) && $stable(nv_cat))
    else $error("request not held");
  a_req_gap: assert property (
    nv_req && nv_ack |=> !nv_req) else $error("no idle gap");
  a_reboot_go: assert property (
    boot_wr |=> reboot_req) else $error("no restart pulse");
  a_reboot_src: assert property (
    reboot_req |-> $past(boot_wr)) else $error("stray restart");
  a_mark_clear: assert property (
    od_obj_write && !mk_wr |=> nv_mark_date == 32'h0
      && nv_mark_time == 32'h0) else $error("marker kept");
  a_mark_take: assert property (
    reg_wr && reg_addr == {psc_pkg::IDX_MARKER, psc_pkg::SUB_DATE}
      && !od_obj_write |=> nv_mark_date == $past(reg_wdata))
    else $error("date not taken");
  c_save: cover property (nv_ack && nv_op == psc_pkg::NV_OP_SAVE);
  c_erase: cover property (nv_ack && nv_op == psc_pkg::NV_OP_ERASE);
  c_boot: cover property (reboot_req);
endmodule // psc_ctrl_sva

bind psc_ctrl psc_ctrl_sva u_sva (.sys_clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .od_obj_write, .nv_req, .nv_op, .nv_cat, .nv_ack,
  .nv_mark_date, .nv_mark_time, .reboot_req);

// ---- bench/psc_nv_model.sv ----
// Behavioural nonvolatile store answering the controller handshake.
`timescale 1ns/1ps
module psc_nv_model
#(
  parameter int          DLY   = 4,
  parameter logic [31:0] DATE0 = 32'h0000_0d01,
  parameter logic [31:0] TIME0 = 32'h0000_0e01
)
(
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        rst,
  // Handshake.
  input wire logic        nv_req,
  input wire logic [1:0]  nv_op,
  input wire logic [5:0]  nv_cat,
  output     logic        nv_ack,
  output     logic        nv_ok,
  output     logic [31:0] nv_load_date,
  output     logic [31:0] nv_load_time,
  input wire logic [31:0] nv_mark_date,
  input wire logic [31:0] nv_mark_time,
  // Bench control and observation.
  input wire logic        fail,
  output     int          ops,
  output     logic [1:0]  last_op,
  output     logic [5:0]  last_cat
);
  logic [31:0] sd;
  logic [31:0] st;
  int          cnt;
  initial
  begin
    sd = DATE0;
    st = TIME0;
    nv_ack = 1'b0;
    nv_ok = 1'b0;
    nv_load_date = 32'h0;
    nv_load_time = 32'h0;
    ops = 0;
    cnt = 0;
  end
  // Stored contents survive reset; only the handshake restarts.
  always @(posedge sys_clk)
  begin
    nv_ack <= 1'b0;
    nv_ok <= ~nv_ok;
    nv_load_date <= ~nv_load_date;
    nv_load_time <= ~nv_load_time;
    if (rst)
      cnt <= 0;
    else if (nv_req && !nv_ack && cnt < DLY)
      cnt <= cnt + 1;
    else if (nv_req && !nv_ack)
    begin
      cnt <= 0;
      nv_ack <= 1'b1;
      nv_ok <= !fail;
      ops <= ops + 1;
      last_op <= nv_op;
      last_cat <= nv_cat;
      nv_load_date <= sd;
      nv_load_time <= st;
      if (nv_op == psc_pkg::NV_OP_SAVE && nv_cat == 6'h2f && !fail)
      begin
        sd <= nv_mark_date;
        st <= nv_mark_time;
      end
    end
  end
endmodule // psc_nv_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the parameter store controller.
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk, rst, reg_wr, reg_rd, od_obj_write, fail;
  logic [23:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, ld_d, ld_t, mk_d, mk_t, v;
  logic        nv_req, nv_ack, nv_ok, reboot_req, irq;
  logic [1:0]  nv_op, last_op;
  logic [5:0]  nv_cat, last_cat;
  int          ops, bad_count, tests_run, n;
  logic [7:0]  subs [6] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0b};
  logic [5:0]  cats [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
  localparam logic [23:0] DT = 24'h102001;
  localparam logic [23:0] ST = 24'h3f0001;

  psc_ctrl u_dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .od_obj_write, .nv_req, .nv_op, .nv_cat,
    .nv_ack, .nv_ok, .nv_load_date(ld_d), .nv_load_time(ld_t),
    .nv_mark_date(mk_d), .nv_mark_time(mk_t), .reboot_req, .irq);
  psc_nv_model u_nv (.sys_clk, .rst, .nv_req, .nv_op, .nv_cat, .nv_ack,
    .nv_ok, .nv_load_date(ld_d), .nv_load_time(ld_t),
    .nv_mark_date(mk_d), .nv_mark_time(mk_t), .fail, .ops, .last_op,
    .last_cat);

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [23:0] a, input logic [31:0] e,
                    input string what);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    // Read data stand in the cycle after the strobe; take them at its end.
    @(posedge sys_clk);
    v = reg_rdata;
    if (what != "") chk(what, e, v);
  endtask
  task automatic poll(input logic [23:0] a);
    v = 32'h0;
    for (int i = 0; i < 100 && v !== psc_pkg::SAVE_DONE; i++)
      rd(a, 32'h0, "");
    chk("save done", psc_pkg::SAVE_DONE, v);
    if (v !== psc_pkg::SAVE_DONE) report_and_stop();
  endtask
  task automatic wait_ops(input int t);
    for (int i = 0; i < 300 && ops < t; i++) @(posedge sys_clk);
    chk("store ops", t, ops);
    if (ops < t) report_and_stop();
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    {rst, reg_wr, reg_rd, od_obj_write, fail} = 5'h10;
    {reg_addr, reg_wdata, bad_count, tests_run} = '0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    wait_ops(1);
    rd(DT, 32'h0000_0d01, "boot date");
    wr(24'h3f0002, 32'h0000_001f);
    // The mask lands at the write's edge; look one cycle later.
    @(posedge sys_clk);
    chk("irq up", 32'h1, irq);
    rd(ST, 32'h0000_0010, "status");
    chk("irq down", 32'h0, irq);
    wr(DT, 32'h0000_0d02);
    wr(24'h102002, 32'h0000_0e02);
    wr(24'h101001, psc_pkg::SIG_SAVE);
    poll(24'h101001);
    chk("save all mask", 32'h2f, last_cat);
    chk("save op", psc_pkg::NV_OP_SAVE, last_op);
    rd(DT, 32'h0000_0d02, "date kept");
    rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    wait_ops(3);
    // Reset cleared the mask; open it again for the error check.
    wr(24'h3f0002, 32'h0000_001f);
    rd(DT, 32'h0000_0d02, "date after restart");
    rd(24'h102002, 32'h0000_0e02, "time after restart");
    @(posedge sys_clk);
    od_obj_write <= 1'b1;
    @(posedge sys_clk);
    od_obj_write <= 1'b0;
    rd(DT, 32'h0, "date cleared");
    wr(DT, 32'h0000_0d03);
    for (int k = 0; k < 6; k++)
    begin
      wr({psc_pkg::IDX_STORE, subs[k]}, psc_pkg::SIG_SAVE);
      poll({psc_pkg::IDX_STORE, subs[k]});
      chk("save mask", cats[k], last_cat);
    end
    rd(DT, 32'h0, "date cleared by save");
    n = ops;
    wr(24'h101003, 32'h1234_5678);
    repeat (10) @(posedge sys_clk);
    chk("no op", n, ops);
    rd(24'h101003, 32'h1234_5678, "kept value");
    wr(24'h101101, psc_pkg::SIG_LOAD);
    wait_ops(n + 1);
    chk("factory mask", 32'h2f, last_cat);
    chk("erase op", psc_pkg::NV_OP_ERASE, last_op);
    wr(24'h101106, psc_pkg::SIG_LOAD);
    wait_ops(n + 2);
    chk("tuning mask", 32'h10, last_cat);
    rd(ST, 32'h0, "");
    fail <= 1'b1;
    wr(24'h101004, psc_pkg::SIG_SAVE);
    wait_ops(n + 3);
    fail <= 1'b0;
    rd(24'h101004, psc_pkg::SIG_SAVE, "failed save");
    chk("irq error", 32'h1, irq);
    rd(ST, 32'h0, "");
    chk("error bit", 32'h08, v & 32'h08);
    wr(24'h280001, psc_pkg::SIG_BOOT);
    // The restart pulse stands for the cycle after the write.
    @(posedge sys_clk);
    chk("restart", 32'h1, reboot_req);
    rd(24'h123401, 32'h0, "unmapped");
    report_and_stop();
  end
endmodule // tb_top
